// ===== logic/battery_charge_sequencer.sv
// What this block does
// [RULE1] Input is good only above battery plus headroom and within under/over limits; interrupt.
// [RULE2] After good input run type detection, update status, pulse interrupt, then enable converter.
// [RULE3] System floor from bits 3..1; tracking offset from bit 0 of same register.
// [RULE4] Battery below floor plus 60mV: switch linear; above: switch full, PWM controls current.
// [RULE5] Suspended or complete: switch off, regulate system to max(floor, battery) plus offset.
// [RULE6] Input current at limit reduces charge current to favour system load.
// [RULE7] Input voltage at floor: input voltage loop controls converter, reduces charge current.
// [RULE8] Overload with zero charge current and system below battery: battery supplement mode.
// [RULE9] Ideal diode on battery-supplied start-up or battery below floor and system below battery.
// [RULE10] Input present, config 01, inhibit pin low: charge cycle runs autonomously.
// [RULE11] New cycle needs good input, enables, no thermistor or timer fault, switch not forced off.
// [RULE12] After qualification, trickle current while battery below 2.0V threshold.
// [RULE13] Trickle current 185mA when bit 4 set, 145mA when clear.
// [RULE14] Pre-charge until exit threshold; 1hr timer expiry ends cycle with timeout fault.
// [RULE15] Pre-charge current from 4-bit field bits 7..4, 150mA to 750mA.
// [RULE16] Above exit threshold (bit 7 select) constant current from 6-bit field bits 5..0.
// [RULE17] Reaching float voltage (bits 7..1) moves to constant voltage, current tapers.
// [RULE18] With termination enabled, current at or below term level for 200ms completes charge.
// [RULE19] Safety timer expiring before termination ends cycle with timeout fault.
// [RULE20] Charge current reduced to hold junction below threshold selected by bits 3..2.
// [RULE21] Comparators are synchronised; charge phase is an explicit clocked state register.
`timescale 1ns/1ps
`default_nettype none
module battery_charge_sequencer
  import charge_seq_pkg::*;
#(
  parameter int unsigned  SYNC_STAGES    = 2,
  parameter longint unsigned PRE_CYCLES  = PRE_TIMEOUT_CYC,
  parameter longint unsigned SAFE_CYCLES = SAFETY_TIMEOUT_CYC,
  parameter int unsigned  TERM_CYCLES    = TERM_DEGLITCH_CYC
) (
  // Clock, reset and enable.
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Analog comparator outputs, asynchronous to sys_clk.
  input  wire logic       cmp_vin_above_batt,
  input  wire logic       cmp_vin_above_uvlo,
  input  wire logic       cmp_vin_below_ovp,
  input  wire logic       cmp_batt_above_floor_gd,
  input  wire logic       cmp_batt_above_floor,
  input  wire logic       cmp_batt_above_trickle,
  input  wire logic       cmp_batt_above_pre_exit,
  input  wire logic       cmp_batt_at_float,
  input  wire logic       cmp_ichg_at_term,
  input  wire logic       cmp_iin_at_limit,
  input  wire logic       cmp_vin_at_floor,
  input  wire logic       cmp_sys_below_batt,
  input  wire logic       cmp_ichg_zero,
  input  wire logic       cmp_tj_above_reg,
  input  wire logic       thermistor_fault,
  // Source detection handshake.
  input  wire logic       detect_done,
  input  wire logic [2:0] detect_type,
  // Configuration fields.
  input  wire logic [3:0] sys_cfg,
  input  wire logic [7:0] pre_term_cfg,
  input  wire logic [7:0] cc_cfg,
  input  wire logic [7:0] float_cfg,
  input  wire logic       term_enable,
  input  wire logic [3:0] therm_cfg,
  input  wire logic [1:0] charge_config_field,
  input  wire logic       charge_inhibit,
  input  wire logic       switch_force_off,
  // Status and control outputs.
  output logic            host_int,
  output logic [2:0]      input_type_status,
  output logic            detect_start,
  output logic            converter_en,
  output logic [2:0]      system_floor_target,
  output logic            track_offset,
  output logic            sys_track_batt,
  output sw_mode_e        battery_switch,
  output phase_e          charge_phase,
  output logic [7:0]      trickle_ma,
  output logic [3:0]      pre_i_code,
  output logic [5:0]      cc_i_code,
  output logic            pre_exit_sel,
  output logic [6:0]      float_code,
  output logic [3:0]      term_i_code,
  output logic [1:0]      therm_sel,
  output logic            ichg_reduce,
  output logic            vin_loop_active,
  output logic            supplement_mode,
  output logic            timeout_fault
);

  localparam int unsigned NCMP = 15;

  // A single stage would pass metastable levels on, and a zero count underflows the timers.
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end
  if (TERM_CYCLES < 1) begin : g_bad_term
    $error("TERM_CYCLES must be at least 1");
  end
  if (PRE_CYCLES < 1 || SAFE_CYCLES < 1) begin : g_bad_timer
    $error("PRE_CYCLES and SAFE_CYCLES must be at least 1");
  end

  // SYNC_STAGES-stage synchroniser (two by default); only the last stage is used by logic.
  logic [NCMP-1:0] cmp_raw;
  logic [NCMP-1:0] sync_q [SYNC_STAGES];
  logic [NCMP-1:0] s;

  assign cmp_raw = {thermistor_fault, cmp_tj_above_reg, cmp_ichg_zero, cmp_sys_below_batt,
                    cmp_vin_at_floor, cmp_iin_at_limit, cmp_ichg_at_term, cmp_batt_at_float,
                    cmp_batt_above_pre_exit, cmp_batt_above_trickle, cmp_batt_above_floor,
                    cmp_batt_above_floor_gd, cmp_vin_below_ovp, cmp_vin_above_uvlo,
                    cmp_vin_above_batt};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < SYNC_STAGES; i++) sync_q[i] <= '0;
    end else if (clk_en) begin
      sync_q[0] <= cmp_raw; // RULE21
      for (int i = 1; i < SYNC_STAGES; i++) sync_q[i] <= sync_q[i-1];
    end
  end
  assign s = sync_q[SYNC_STAGES-1];

  logic vin_good;
  logic batt_gd, batt_floor, batt_tc, batt_pre, batt_float, i_term;
  logic iin_lim, vin_floor, sys_lo, ichg_zero, tj_hot, ntc_fault;
  assign vin_good   = s[0] & s[1] & s[2]; // RULE1
  assign batt_gd    = s[3];
  assign batt_floor = s[4];
  assign batt_tc    = s[5];
  assign batt_pre   = s[6];
  assign batt_float = s[7];
  assign i_term     = s[8];
  assign iin_lim    = s[9];
  assign vin_floor  = s[10];
  assign sys_lo     = s[11];
  assign ichg_zero  = s[12];
  assign tj_hot     = s[13];
  assign ntc_fault  = s[14];

  // Start-up: qualify, detect, then run the converter.
  startup_e su_q;
  logic     batt_sourced_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      su_q              <= SU_WAIT;
      host_int          <= 1'b0;
      detect_start      <= 1'b0;
      converter_en      <= 1'b0;
      input_type_status <= 3'h0;
      batt_sourced_q    <= 1'b0;
    end else if (clk_en) begin
      host_int     <= 1'b0;
      detect_start <= 1'b0;
      batt_sourced_q <= 1'b0;
      case (su_q)
        SU_WAIT: begin
          converter_en <= 1'b0;
          if (vin_good) begin
            host_int       <= 1'b1; // RULE1
            detect_start   <= 1'b1; // RULE2
            batt_sourced_q <= 1'b1;
            su_q           <= SU_DETECT;
          end
        end
        SU_DETECT: begin
          if (!vin_good) begin
            su_q <= SU_WAIT;
          end else if (detect_done) begin
            input_type_status <= detect_type; // RULE2
            host_int          <= 1'b1;
            su_q              <= SU_RUN;
          end
        end
        SU_RUN: begin
          converter_en <= vin_good; // RULE2
          if (!vin_good) su_q <= SU_WAIT;
        end
        default: su_q <= SU_WAIT;
      endcase
    end
  end

  // Field decode.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      system_floor_target <= 3'h0;
      track_offset        <= 1'b0;
      trickle_ma          <= TRICKLE_LO_MA;
      pre_i_code          <= 4'h0;
      term_i_code         <= 4'h0;
      cc_i_code           <= 6'h0;
      pre_exit_sel        <= 1'b0;
      float_code          <= 7'h0;
      therm_sel           <= 2'h0;
    end else if (clk_en) begin
      system_floor_target <= sys_cfg[SYS_FLOOR_MSB:SYS_FLOOR_LSB]; // RULE3
      track_offset        <= sys_cfg[TRACK_BIT]; // RULE3
      trickle_ma <= pre_term_cfg[TRICKLE_SEL_BIT] ? TRICKLE_HI_MA : TRICKLE_LO_MA; // RULE13
      pre_i_code   <= pre_term_cfg[PRE_I_MSB:PRE_I_LSB]; // RULE15
      term_i_code  <= pre_term_cfg[TERM_I_MSB:TERM_I_LSB];
      cc_i_code    <= cc_cfg[CC_I_MSB:CC_I_LSB]; // RULE16
      pre_exit_sel <= cc_cfg[PRE_EXIT_BIT]; // RULE16
      float_code   <= float_cfg[FLOAT_MSB:FLOAT_LSB]; // RULE17
      therm_sel    <= therm_cfg[THERM_MSB:THERM_LSB]; // RULE20
    end
  end

  // Charge phase machine with timers.
  logic   chg_enable, can_start;
  phase_e ph_d;
  logic [63:0] tmr_q;
  logic [31:0] term_q;
  assign chg_enable = (charge_config_field == CHG_CFG_ENABLE) && !charge_inhibit; // RULE10
  assign can_start  = converter_en && chg_enable && !ntc_fault && !timeout_fault
                      && !switch_force_off; // RULE11

  always_comb begin
    ph_d = charge_phase;
    case (charge_phase)
      PH_IDLE: begin
        if (can_start) begin
          if (!batt_tc)       ph_d = PH_TRICKLE; // RULE12
          else if (!batt_pre) ph_d = PH_PRE;
          else                ph_d = PH_CC;
        end
      end
      PH_TRICKLE: if (batt_tc) ph_d = PH_PRE;
      PH_PRE: begin
        if (batt_pre) ph_d = PH_CC; // RULE14
        else if (tmr_q >= PRE_CYCLES - 64'd1) ph_d = PH_FAULT; // RULE14
      end
      PH_CC: begin
        if (tmr_q >= SAFE_CYCLES - 64'd1) ph_d = PH_FAULT; // RULE19
        else if (batt_float) ph_d = PH_CV; // RULE17
      end
      PH_CV: begin
        if (term_enable && i_term && term_q >= TERM_CYCLES - 1) ph_d = PH_DONE; // RULE18
        else if (tmr_q >= SAFE_CYCLES - 64'd1) ph_d = PH_FAULT; // RULE19
      end
      PH_DONE:  ph_d = PH_DONE;
      PH_FAULT: ph_d = PH_FAULT;
      default:  ph_d = PH_IDLE;
    endcase
    if (charge_phase inside {PH_TRICKLE, PH_PRE, PH_CC, PH_CV} &&
        (!converter_en || !chg_enable || ntc_fault || switch_force_off)) ph_d = PH_IDLE;
    if ((charge_phase == PH_DONE || charge_phase == PH_FAULT) && !converter_en) ph_d = PH_IDLE;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      charge_phase  <= PH_IDLE;
      timeout_fault <= 1'b0;
    end else if (clk_en) begin
      charge_phase <= ph_d; // RULE21
      if (ph_d == PH_FAULT) timeout_fault <= 1'b1; // RULE14 RULE19
      else if (!converter_en) timeout_fault <= 1'b0;
    end
  end

  // Pre-charge timer restarts per phase; safety timer spans CC and CV.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tmr_q <= 64'd0;
    end else if (clk_en) begin
      if (ph_d != charge_phase && !(charge_phase == PH_CC && ph_d == PH_CV)) tmr_q <= 64'd0;
      else tmr_q <= tmr_q + 64'd1;
    end
  end

  // Termination deglitch: current must stay low continuously.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      term_q <= 32'd0;
    end else if (clk_en) begin
      if (charge_phase == PH_CV && i_term) term_q <= term_q + 32'd1; // RULE18
      else term_q <= 32'd0;
    end
  end

  // Power path: switch mode, system target and loop controls.
  logic charging;
  assign charging = charge_phase inside {PH_TRICKLE, PH_PRE, PH_CC, PH_CV};
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      battery_switch  <= SW_OFF;
      sys_track_batt  <= 1'b0;
      ichg_reduce     <= 1'b0;
      vin_loop_active <= 1'b0;
      supplement_mode <= 1'b0;
    end else if (clk_en) begin
      if (batt_sourced_q || (!batt_floor && sys_lo)) battery_switch <= SW_DIODE; // RULE9
      else if (!charging) battery_switch <= SW_OFF; // RULE5
      else if (batt_gd) battery_switch <= SW_FULL; // RULE4
      else battery_switch <= SW_LINEAR; // RULE4
      sys_track_batt  <= !charging && batt_floor; // RULE5
      vin_loop_active <= converter_en && vin_floor; // RULE7
      ichg_reduce     <= charging && (iin_lim || vin_floor || tj_hot); // RULE6 RULE7 RULE20
      supplement_mode <= (iin_lim || vin_floor) && ichg_zero && sys_lo; // RULE8
    end
  end

  // Assertions.
  sequence seq_good_in;
    vin_good && su_q == SU_WAIT && clk_en;
  endsequence

  sequence seq_det_done;
    su_q == SU_DETECT && vin_good && detect_done && clk_en;
  endsequence

  AST_GOOD_INT: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
    seq_good_in |=> host_int && detect_start)
    else $error("good input did not raise interrupt");
  AST_DET_STATUS: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE2
    seq_det_done |=> host_int && !converter_en && input_type_status == $past(detect_type))
    else $error("detection result not reported before converter start");
  AST_CONV_AFTER_DET: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE2
    $rose(converter_en) |-> su_q == SU_RUN && $past(su_q) == SU_RUN)
    else $error("converter enabled before detection done");
  AST_FLOOR: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE3
    clk_en |=> system_floor_target == $past(sys_cfg[SYS_FLOOR_MSB:SYS_FLOOR_LSB]))
    else $error("floor field not taken");
  AST_SW_FULL: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE4
    battery_switch == SW_FULL |-> $past(charging && batt_gd))
    else $error("switch full without margin");
  AST_SW_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE5
    clk_en && !charging && !batt_sourced_q && !(!batt_floor && sys_lo)
    |=> battery_switch == SW_OFF)
    else $error("switch not off when idle");
  AST_REDUCE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE6
    clk_en && charging && iin_lim |=> ichg_reduce)
    else $error("charge current not reduced at input limit");
  AST_SUPP: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE8
    clk_en && vin_floor && ichg_zero && sys_lo |=> supplement_mode)
    else $error("supplement mode missed");
  AST_TRICKLE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE12
    clk_en && charge_phase == PH_IDLE && can_start && !batt_tc |=> charge_phase == PH_TRICKLE)
    else $error("trickle not entered");
  AST_NO_START: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE11
    charge_phase == PH_IDLE && !can_start |=> charge_phase == PH_IDLE)
    else $error("cycle started without conditions");
  AST_TERM: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE18
    $rose(charge_phase == PH_DONE) |-> $past(term_enable) && $past(term_q) >= TERM_CYCLES - 1)
    else $error("termination without deglitch");
  AST_FAULT: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE19
    charge_phase == PH_FAULT |-> timeout_fault)
    else $error("fault phase without timeout flag");

endmodule
`default_nettype wire

// ===== logic/charge_seq_pkg.sv
`default_nettype none
package charge_seq_pkg;

  // Clock and timing.
  localparam int unsigned CLK_HZ            = 100_000_000;
  localparam int unsigned TERM_DEGLITCH_MS  = 200;
  localparam int unsigned TERM_DEGLITCH_CYC = CLK_HZ / 1000 * TERM_DEGLITCH_MS;
  localparam int unsigned PRE_TIMEOUT_HR    = 1;
  localparam longint unsigned PRE_TIMEOUT_CYC =
    64'(CLK_HZ) * 64'(3600) * 64'(PRE_TIMEOUT_HR);
  localparam int unsigned SAFETY_TIMEOUT_HR  = 20;
  localparam longint unsigned SAFETY_TIMEOUT_CYC =
    64'(CLK_HZ) * 64'(3600) * 64'(SAFETY_TIMEOUT_HR);

  // Configuration field positions.
  localparam int unsigned SYS_FLOOR_MSB   = 3;
  localparam int unsigned SYS_FLOOR_LSB   = 1;
  localparam int unsigned TRACK_BIT       = 0;
  localparam int unsigned TRICKLE_SEL_BIT = 4;
  localparam int unsigned PRE_I_MSB       = 7;
  localparam int unsigned PRE_I_LSB       = 4;
  localparam int unsigned TERM_I_MSB      = 3;
  localparam int unsigned TERM_I_LSB      = 0;
  localparam int unsigned PRE_EXIT_BIT    = 7;
  localparam int unsigned CC_I_MSB        = 5;
  localparam int unsigned CC_I_LSB        = 0;
  localparam int unsigned FLOAT_MSB       = 7;
  localparam int unsigned FLOAT_LSB       = 1;
  localparam int unsigned TERM_EN_BIT     = 7;
  localparam int unsigned THERM_MSB       = 3;
  localparam int unsigned THERM_LSB       = 2;

  // Charge enable code of the charge configuration field.
  localparam logic [1:0] CHG_CFG_ENABLE = 2'h1;

  // Trickle current codes in mA.
  localparam logic [7:0] TRICKLE_HI_MA = 8'hb9;
  localparam logic [7:0] TRICKLE_LO_MA = 8'h91;

  // Battery switch modes.
  typedef enum logic [1:0] {
    SW_OFF    = 2'b00,
    SW_LINEAR = 2'b01,
    SW_FULL   = 2'b10,
    SW_DIODE  = 2'b11
  } sw_mode_e;

  // Charge phases.
  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_TRICKLE = 3'b001,
    PH_PRE     = 3'b010,
    PH_CC      = 3'b011,
    PH_CV      = 3'b100,
    PH_DONE    = 3'b101,
    PH_FAULT   = 3'b110
  } phase_e;

  // Start-up sequence.
  typedef enum logic [1:0] {
    SU_WAIT   = 2'b00,
    SU_DETECT = 2'b01,
    SU_RUN    = 2'b10
  } startup_e;

endpackage
`default_nettype wire

// ===== testbench/detect_responder.sv
`timescale 1ns/1ps
`default_nettype none
module detect_responder #(
  parameter int unsigned DELAY = 5
) (
  // Clock.
  input  wire logic       sys_clk,
  // Detection handshake.
  input  wire logic       detect_start,
  input  wire logic [2:0] type_sel,
  output logic            detect_done,
  output logic [2:0]      detect_type
);
  int cnt = 0;
  // Outside the done cycle the code shows its inverse, so early sampling is caught.
  always @(negedge sys_clk) begin
    detect_done <= 1'b0;
    detect_type <= ~type_sel;
    if (detect_start) begin
      cnt <= DELAY;
    end else if (cnt == 1) begin
      detect_done <= 1'b1;
      detect_type <= type_sel;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import charge_seq_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic vin_ab = 1'b0, vin_uv = 1'b0, vin_ov = 1'b0, b_gd = 1'b0, b_fl = 1'b0;
  logic b_tc = 1'b0, b_pre = 1'b0, b_flt = 1'b0, i_term = 1'b0, i_lim = 1'b0;
  logic vin_fl = 1'b0, sys_lo = 1'b0, i_zero = 1'b0, tj_hi = 1'b0, th_flt = 1'b0;
  logic term_en = 1'b1, inhibit = 1'b0, force_off = 1'b0, clk_en = 1'b1;
  logic [1:0] cfg = 2'h1;
  logic [3:0] sys_cfg = 4'h0, therm_cfg = 4'h0;
  logic [7:0] pt_cfg = 8'h00, cc_cfg = 8'h00, fl_cfg = 8'h00;
  logic [2:0] type_sel = 3'h5, det_type, int_type;
  logic det_done, det_start, host_int, conv_en, track, trk_batt, red, vloop, supp, tmo;
  logic pre_sel;
  logic [2:0] floor_t;
  logic [7:0] trickle;
  logic [3:0] pre_i, term_i;
  logic [5:0] cc_i;
  logic [6:0] float_c;
  logic [1:0] th_sel;
  sw_mode_e sw;
  phase_e ph;
  int error_cnt = 0, check_count = 0, int_cnt = 0, cyc_cnt = 0, det_cnt = 0;

  always #5 sys_clk = ~sys_clk;

  battery_charge_sequencer #(.PRE_CYCLES(50), .SAFE_CYCLES(400), .TERM_CYCLES(10)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .cmp_vin_above_batt(vin_ab), .cmp_vin_above_uvlo(vin_uv), .cmp_vin_below_ovp(vin_ov),
    .cmp_batt_above_floor_gd(b_gd), .cmp_batt_above_floor(b_fl),
    .cmp_batt_above_trickle(b_tc), .cmp_batt_above_pre_exit(b_pre),
    .cmp_batt_at_float(b_flt), .cmp_ichg_at_term(i_term), .cmp_iin_at_limit(i_lim),
    .cmp_vin_at_floor(vin_fl), .cmp_sys_below_batt(sys_lo), .cmp_ichg_zero(i_zero),
    .cmp_tj_above_reg(tj_hi), .thermistor_fault(th_flt), .detect_done(det_done),
    .detect_type(det_type), .sys_cfg(sys_cfg), .pre_term_cfg(pt_cfg), .cc_cfg(cc_cfg),
    .float_cfg(fl_cfg), .term_enable(term_en), .therm_cfg(therm_cfg),
    .charge_config_field(cfg), .charge_inhibit(inhibit), .switch_force_off(force_off),
    .host_int(host_int), .input_type_status(int_type), .detect_start(det_start),
    .converter_en(conv_en), .system_floor_target(floor_t), .track_offset(track),
    .sys_track_batt(trk_batt), .battery_switch(sw), .charge_phase(ph),
    .trickle_ma(trickle), .pre_i_code(pre_i), .cc_i_code(cc_i), .pre_exit_sel(pre_sel),
    .float_code(float_c), .term_i_code(term_i), .therm_sel(th_sel), .ichg_reduce(red),
    .vin_loop_active(vloop), .supplement_mode(supp), .timeout_fault(tmo)
  );

  detect_responder #(.DELAY(5)) u_src (
    .sys_clk(sys_clk), .detect_start(det_start), .type_sel(type_sel),
    .detect_done(det_done), .detect_type(det_type)
  );

  always @(posedge sys_clk) begin
    if (host_int === 1'b1) int_cnt++;
    if (det_start === 1'b1) det_cnt++;
  end

  // The run needs well under 3000 cycles; the ceiling leaves ample margin.
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      $display("[FAIL] %0t ns: run did not finish", $time);
      print_verdict();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_phase(input phase_e p, input int n);
    for (int i = 0; i < n && ph !== p; i++) cyc(1);
    check_val(ph, p, "phase");
  endtask

  task automatic start_up();
    int base;
    int dbase;
    base = int_cnt;
    dbase = det_cnt;
    {vin_ab, vin_uv, vin_ov} = 3'h7;
    cyc(6);
    check_val(8'(int_cnt - base), 8'h1, "good input interrupt");
    check_val(8'(det_cnt - dbase), 8'h1, "detection request");
    check_val(conv_en, 1'b0, "converter before detection");
    for (int i = 0; i < 30 && conv_en !== 1'b1; i++) cyc(1);
    check_val(8'(int_cnt - base), 8'h2, "detection interrupt");
    check_val(int_type, type_sel, "input type");
    check_val(conv_en, 1'b1, "converter on");
  endtask

  task automatic drop_input();
    {vin_ab, b_tc, b_pre, b_flt, i_term} = 5'h0;
    cyc(8);
    check_val(conv_en, 1'b0, "converter off");
    check_val(ph, PH_IDLE, "phase idle");
    check_val(tmo, 1'b0, "fault cleared");
  endtask

  task automatic t_reset();
    check_val(ph, PH_IDLE, "reset phase");
    check_val(trickle, TRICKLE_LO_MA, "reset trickle");
    check_val({conv_en, tmo, host_int}, 3'h0, "reset outputs");
  endtask

  task automatic t_fields();
    {sys_cfg, pt_cfg, cc_cfg, fl_cfg, therm_cfg} = {4'hb, 8'h5a, 8'ha7, 8'hd3, 4'h8};
    cyc(3);
    check_val({floor_t, track}, 4'hb, "floor and track");
    check_val(trickle, TRICKLE_HI_MA, "trickle high");
    check_val({pre_i, term_i}, 8'h5a, "pre and term codes");
    check_val({pre_sel, cc_i}, 7'h67, "exit select and cc code");
    check_val(float_c, 7'h69, "float code");
    check_val(th_sel, 2'h2, "thermal select");
    pt_cfg = 8'ha5;
    cyc(3);
    check_val(trickle, TRICKLE_LO_MA, "trickle low");
    check_val({pre_i, term_i}, 8'ha5, "pre and term codes");
    clk_en = 1'b0;
    sys_cfg = 4'h4;
    cyc(4);
    check_val({floor_t, track}, 4'hb, "frozen while enable low");
    clk_en = 1'b1;
    cyc(3);
    check_val({floor_t, track}, 4'h4, "floor after enable");
  endtask

  task automatic t_bad_input();
    for (int k = 0; k < 3; k++) begin
      {vin_ab, vin_uv, vin_ov} = 3'h7 ^ (3'h1 << k);
      cyc(12);
      check_val(8'(int_cnt), 8'h0, "no interrupt");
      check_val(conv_en, 1'b0, "converter stays off");
    end
  endtask

  task automatic t_profile();
    start_up();
    wait_phase(PH_TRICKLE, 10);
    b_tc = 1'b1;
    wait_phase(PH_PRE, 10);
    b_pre = 1'b1;
    wait_phase(PH_CC, 10);
    cyc(3);
    check_val(sw, SW_LINEAR, "switch linear");
    {b_gd, b_fl} = 2'h3;
    cyc(6);
    check_val(sw, SW_FULL, "switch full");
    b_flt = 1'b1;
    wait_phase(PH_CV, 10);
    i_term = 1'b1;
    cyc(8);
    check_val(ph, PH_CV, "still deglitching");
    wait_phase(PH_DONE, 20);
    cyc(3);
    check_val({sw, trk_batt}, {SW_OFF, 1'b1}, "switch off, system tracks");
    drop_input();
  endtask

  task automatic t_pre_timeout();
    b_tc = 1'b1;
    start_up();
    wait_phase(PH_PRE, 10);
    cyc(20);
    check_val(ph, PH_PRE, "pre before timeout");
    wait_phase(PH_FAULT, 60);
    check_val(tmo, 1'b1, "pre timeout fault");
    drop_input();
  endtask

  task automatic t_loops_safety();
    {b_tc, b_pre, b_gd, b_fl} = 4'hf;
    start_up();
    wait_phase(PH_CC, 10);
    check_val({red, vloop, supp}, 3'h0, "no limiting");
    {i_lim, tj_hi, vin_fl, i_zero, sys_lo} = 5'h10;
    cyc(6);
    check_val(red, 1'b1, "input current limit");
    {i_lim, tj_hi} = 2'h1;
    cyc(6);
    check_val(red, 1'b1, "thermal limit");
    {tj_hi, vin_fl} = 2'h1;
    cyc(6);
    check_val({red, vloop}, 2'h3, "input voltage loop");
    {i_lim, vin_fl, i_zero, sys_lo} = 4'hf;
    cyc(6);
    check_val(supp, 1'b1, "supplement mode");
    {i_lim, i_zero, b_fl, b_gd} = 4'h0;
    cyc(6);
    check_val(sw, SW_DIODE, "ideal diode");
    {sys_lo, vin_fl, b_fl, b_gd} = 4'h3;
    cyc(6);
    check_val({red, vloop, supp, ph}, {3'h0, PH_CC}, "limits released");
    wait_phase(PH_FAULT, 400);
    check_val(tmo, 1'b1, "safety timeout fault");
    drop_input();
  endtask

  task automatic t_blockers();
    for (int k = 0; k < 5; k++) begin
      {cfg, inhibit, th_flt, force_off} = {2'h1, 3'h0};
      case (k)
        0: cfg = 2'h0;
        1: cfg = 2'h2;
        2: inhibit = 1'b1;
        3: th_flt = 1'b1;
        default: force_off = 1'b1;
      endcase
      start_up();
      cyc(10);
      check_val(ph, PH_IDLE, "cycle blocked");
      drop_input();
    end
    {cfg, inhibit, th_flt, force_off} = {2'h1, 3'h0};
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    cyc(3);
    rst_n = 1'b1;
    cyc(1);
    t_reset();
    t_fields();
    t_bad_input();
    t_profile();
    t_pre_timeout();
    t_loops_safety();
    t_blockers();
    print_verdict();
  end
endmodule
`default_nettype wire
